// ---- verilog/rtcal_pkg.sv ----
package rtcal_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] RTCAL_CLOCK_CTRL_ADDR = 8'h00;
  localparam logic [7:0] RTCAL_ALARM_CTRL_ADDR = 8'h04;
  localparam logic [7:0] RTCAL_ALARM_TIME_ADDR = 8'h08;
  localparam logic [7:0] RTCAL_ALARM_DATE_ADDR = 8'h0C;
  localparam logic [7:0] RTCAL_IRQ_CTRL_ADDR   = 8'h10;
  localparam logic [7:0] RTCAL_STATUS_ADDR     = 8'h14;
  // ==========================================================
  // Clock control register fields
  localparam int RTCAL_ON_BIT      = 15;
  localparam int RTCAL_PCLK_BIT    = 8;
  localparam int RTCAL_OUT_SEL_BIT = 7;
  localparam int RTCAL_PIN_OE_BIT  = 0;
  // ==========================================================
  // Alarm control register fields
  localparam int RTCAL_ALARM_EN_BIT = 15;
  localparam int RTCAL_CHIME_BIT    = 14;
  localparam int RTCAL_PIV_BIT      = 13;
  localparam int RTCAL_SYNC_BIT     = 12;
  localparam int RTCAL_MASK_LSB     = 8;
  localparam int RTCAL_RPT_LSB      = 0;
  // ==========================================================
  // Interrupt control register fields
  localparam int RTCAL_FLAG_BIT  = 0;
  localparam int RTCAL_IE_BIT    = 1;
  localparam int RTCAL_GROUP_LSB = 2;
  localparam int RTCAL_SUB_LSB   = 5;
  // ==========================================================
  // Reset values and timing
  localparam logic [31:0] RTCAL_ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0]  RTCAL_RPT_WRAP  = 8'hFF;
  localparam int RTCAL_CLK_PERIOD_NS   = 25;
  localparam int RTCAL_ALARM_DELAY_NS  = 25;
  localparam int RTCAL_ALARM_DELAY_CYC =
    (RTCAL_ALARM_DELAY_NS + RTCAL_CLK_PERIOD_NS - 1) / RTCAL_CLK_PERIOD_NS;
  // ==========================================================
  // Mask codes
  localparam logic [3:0] RTCAL_M_HALF  = 4'h0;
  localparam logic [3:0] RTCAL_M_SEC   = 4'h1;
  localparam logic [3:0] RTCAL_M_10SEC = 4'h2;
  localparam logic [3:0] RTCAL_M_MIN   = 4'h3;
  localparam logic [3:0] RTCAL_M_10MIN = 4'h4;
  localparam logic [3:0] RTCAL_M_HOUR  = 4'h5;
  localparam logic [3:0] RTCAL_M_DAY   = 4'h6;
  localparam logic [3:0] RTCAL_M_WEEK  = 4'h7;
  localparam logic [3:0] RTCAL_M_MONTH = 4'h8;
  localparam logic [3:0] RTCAL_M_YEAR  = 4'h9;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] weekday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic       halfsec;
  } rtcal_time_type;

  typedef struct packed {
    logic [2:0] group;
    logic [1:0] sub;
  } rtcal_prio_type;
endpackage : rtcal_pkg

// ---- verilog/rtcal_alarm.sv ----
`timescale 1ns/10ps
module rtcal_alarm
  import rtcal_pkg::*;
#(
  parameter logic [5:0] ALARM_VECTOR = 6'h10
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic           hready,
  input  wire logic [31:0]    hwdata,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire rtcal_time_type time_now,
  input  wire logic           time_tick,
  input  wire logic           seconds_clk,
  input  wire logic           prescaler_clk,
  input  wire logic [2:0]     cpu_level,
  input  wire logic           sleep_mode,
  input  wire logic           deep_sleep,
  input  wire logic           peer_request,
  input  wire rtcal_prio_type peer_prio,
  input  wire logic [5:0]     peer_vector,
  output logic                irq_request,
  output logic [5:0]          irq_vector,
  output logic                wake_request,
  output logic                rtc_pin_out,
  output logic                rtc_pin_oe
);

  // ==========================================================
  // Match decoding
  function automatic logic mask_match(input logic [3:0] m,
                                      input rtcal_time_type t,
                                      input rtcal_time_type a);
    logic s_lo;
    logic s_hi;
    logic n_lo;
    logic n_hi;
    logic h;
    s_lo = t.seconds[3:0] == a.seconds[3:0];
    s_hi = t.seconds[7:4] == a.seconds[7:4];
    n_lo = t.minutes[3:0] == a.minutes[3:0];
    n_hi = t.minutes[7:4] == a.minutes[7:4];
    h    = t.hours == a.hours;
    case (m)
      RTCAL_M_HALF:  mask_match = 1'b1;
      RTCAL_M_SEC:   mask_match = !t.halfsec;
      RTCAL_M_10SEC: mask_match = !t.halfsec && s_lo;
      RTCAL_M_MIN:   mask_match = !t.halfsec && s_lo && s_hi;
      RTCAL_M_10MIN: mask_match = !t.halfsec && s_lo && s_hi && n_lo;
      RTCAL_M_HOUR:  mask_match = !t.halfsec && s_lo && s_hi && n_lo && n_hi;
      RTCAL_M_DAY:   mask_match = !t.halfsec && s_lo && s_hi && n_lo && n_hi
                                  && h;
      RTCAL_M_WEEK:  mask_match = !t.halfsec && s_lo && s_hi && n_lo && n_hi
                                  && h && t.weekday == a.weekday;
      RTCAL_M_MONTH: mask_match = !t.halfsec && s_lo && s_hi && n_lo && n_hi
                                  && h && t.day == a.day;
      RTCAL_M_YEAR:  mask_match = !t.halfsec && s_lo && s_hi && n_lo && n_hi
                                  && h && t.day == a.day
                                  && t.month == a.month;
      default:       mask_match = 1'b0;
    endcase
  endfunction : mask_match

  // ==========================================================
  // Register state
  logic           clk_on;
  logic           pclk_sel;
  logic           out_sel;
  logic           pin_oe_en;
  logic           alarm_en;
  logic           chime;
  logic           pulse_initial_value;
  logic [3:0]     alarm_mask;
  logic [7:0]     rpt_count;
  rtcal_time_type alarm_set;
  logic           alarm_flag;
  logic           irq_enable;
  rtcal_prio_type prio;
  logic           pulse;
  logic           match_hit;
  logic           dp_write;
  logic [7:0]     dp_addr;
  logic [2:0]     pclk_sync;
  logic           pclk_level;

  // Bus decode and data phase strobes
  logic addr_ok;
  logic wr_clock;
  logic wr_alarm;
  logic wr_time;
  logic wr_date;
  logic wr_irq;
  logic flag_clear;
  logic alarm_event;
  logic alarm_sync;
  logic alarm_wins;
  logic next_irq;
  logic next_wake;
  logic next_pin;
  logic [31:0] next_rdata;

  assign addr_ok  = hsel && hready && htrans[1];
  assign wr_clock = dp_write && dp_addr == RTCAL_CLOCK_CTRL_ADDR;
  assign wr_alarm = dp_write && dp_addr == RTCAL_ALARM_CTRL_ADDR;
  assign wr_time  = dp_write && dp_addr == RTCAL_ALARM_TIME_ADDR;
  assign wr_date  = dp_write && dp_addr == RTCAL_ALARM_DATE_ADDR;
  assign wr_irq   = dp_write && dp_addr == RTCAL_IRQ_CTRL_ADDR;
  // Write one to the flag bit clears it
  assign flag_clear = wr_irq && hwdata[RTCAL_FLAG_BIT];
  // Event one clock after the compare caught the match
  assign alarm_event = match_hit;
  // Busy window around a compare; safe to edit alarm while low
  assign alarm_sync = clk_on && alarm_en && (time_tick || match_hit);

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= addr_ok && hwrite && haddr[31:8] == 24'h000000;
      dp_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = RTCAL_ZERO_WORD;
    case (haddr[7:0])
      RTCAL_CLOCK_CTRL_ADDR: begin
        next_rdata[RTCAL_ON_BIT]      = clk_on;
        next_rdata[RTCAL_PCLK_BIT]    = pclk_sel;
        next_rdata[RTCAL_OUT_SEL_BIT] = out_sel;
        next_rdata[RTCAL_PIN_OE_BIT]  = pin_oe_en;
      end
      RTCAL_ALARM_CTRL_ADDR: begin
        next_rdata[RTCAL_ALARM_EN_BIT] = alarm_en;
        next_rdata[RTCAL_CHIME_BIT]    = chime;
        next_rdata[RTCAL_PIV_BIT]      = pulse_initial_value;
        next_rdata[RTCAL_SYNC_BIT]     = alarm_sync;
        next_rdata[RTCAL_MASK_LSB+:4]  = alarm_mask;
        next_rdata[RTCAL_RPT_LSB+:8]   = rpt_count;
      end
      RTCAL_ALARM_TIME_ADDR:
        next_rdata = {alarm_set.hours, alarm_set.minutes,
                      alarm_set.seconds, 8'h00};
      RTCAL_ALARM_DATE_ADDR:
        next_rdata = {8'h00, alarm_set.month, alarm_set.day,
                      alarm_set.weekday};
      RTCAL_IRQ_CTRL_ADDR: begin
        next_rdata[RTCAL_FLAG_BIT]     = alarm_flag;
        next_rdata[RTCAL_IE_BIT]       = irq_enable;
        next_rdata[RTCAL_GROUP_LSB+:3] = prio.group;
        next_rdata[RTCAL_SUB_LSB+:2]   = prio.sub;
      end
      RTCAL_STATUS_ADDR:
        next_rdata[2:0] = {pulse, irq_request, wake_request};
      default: next_rdata = RTCAL_ZERO_WORD;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      next_rdata = RTCAL_ZERO_WORD;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RTCAL_ZERO_WORD;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================
  // Clock control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_on    <= 1'b0;
      pclk_sel  <= 1'b0;
      out_sel   <= 1'b0;
      pin_oe_en <= 1'b0;
    end else if (wr_clock) begin
      clk_on    <= hwdata[RTCAL_ON_BIT];
      pclk_sel  <= hwdata[RTCAL_PCLK_BIT];
      out_sel   <= hwdata[RTCAL_OUT_SEL_BIT];
      pin_oe_en <= hwdata[RTCAL_PIN_OE_BIT];
    end
  end

  // Alarm time and date; no guard here, software owns the timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_set <= '0;
    end else begin
      if (wr_time) begin
        alarm_set.hours   <= hwdata[31:24];
        alarm_set.minutes <= hwdata[23:16];
        alarm_set.seconds <= hwdata[15:8];
      end
      if (wr_date) begin
        alarm_set.month   <= hwdata[23:16];
        alarm_set.day     <= hwdata[15:8];
        alarm_set.weekday <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Compare on each half-second tick; flag follows two clocks later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_hit <= 1'b0;
    end else begin
      match_hit <= time_tick && clk_on && alarm_en
                   && mask_match(alarm_mask, time_now, alarm_set);
    end
  end

  // Alarm control: software write wins over the repeat bookkeeping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_en   <= 1'b0;
      chime      <= 1'b0;
      pulse_initial_value        <= 1'b0;
      alarm_mask <= 4'h0;
      rpt_count  <= 8'h00;
    end else if (wr_alarm) begin
      alarm_en   <= hwdata[RTCAL_ALARM_EN_BIT];
      chime      <= hwdata[RTCAL_CHIME_BIT];
      pulse_initial_value        <= hwdata[RTCAL_PIV_BIT];
      alarm_mask <= hwdata[RTCAL_MASK_LSB+:4];
      rpt_count  <= hwdata[RTCAL_RPT_LSB+:8];
    end else if (alarm_event) begin
      // Final alarm leaves the count at zero; only chime wraps it
      if (rpt_count == 8'h00 && !chime) begin
        alarm_en <= 1'b0;
      end else begin
        rpt_count <= rpt_count - 8'h01;
      end
    end
  end

  // Pulse: load on enabling, invert per event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse <= 1'b0;
    end else if (wr_alarm && hwdata[RTCAL_ALARM_EN_BIT] && !alarm_en) begin
      pulse <= hwdata[RTCAL_PIV_BIT];
    end else if (alarm_event) begin
      pulse <= !pulse;
    end
  end

  // Flag: a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_flag <= 1'b0;
    end else if (alarm_event) begin
      alarm_flag <= 1'b1;
    end else if (flag_clear) begin
      alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable <= 1'b0;
      prio       <= '0;
    end else if (wr_irq) begin
      irq_enable <= hwdata[RTCAL_IE_BIT];
      prio.group <= hwdata[RTCAL_GROUP_LSB+:3];
      prio.sub   <= hwdata[RTCAL_SUB_LSB+:2];
    end
  end

  // ==========================================================
  // Interrupt arbitration against one competing source
  always_comb begin
    if (!peer_request) begin
      alarm_wins = 1'b1;
    end else if (prio.group != peer_prio.group) begin
      alarm_wins = prio.group > peer_prio.group;
    end else if (prio.sub != peer_prio.sub) begin
      alarm_wins = prio.sub > peer_prio.sub;
    end else begin
      alarm_wins = ALARM_VECTOR < peer_vector;
    end
    // Strict compare: equal group never preempts the running level
    next_irq = alarm_flag && irq_enable && prio.group != 3'h0
               && prio.group > cpu_level && alarm_wins;
    if (deep_sleep) begin
      next_wake = alarm_flag;
    end else if (sleep_mode) begin
      next_wake = alarm_flag && irq_enable && prio.group != 3'h0
                  && prio.group > cpu_level;
    end else begin
      next_wake = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_request  <= 1'b0;
      wake_request <= 1'b0;
      irq_vector   <= 6'h00;
    end else begin
      irq_request  <= next_irq;
      wake_request <= next_wake;
      irq_vector   <= ALARM_VECTOR;
    end
  end

  // ==========================================================
  // Prescaler clock from the oscillator: three-stage synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_sync  <= 3'h0;
      pclk_level <= 1'b0;
    end else begin
      pclk_sync <= {pclk_sync[1:0], prescaler_clk};
      if (pclk_sync[1] == pclk_sync[2]) begin
        pclk_level <= pclk_sync[2];
      end
    end
  end

  // Pin mux; the fast source is only as good as the sampling allows
  always_comb begin
    if (pclk_sel) begin
      next_pin = pclk_level;
    end else if (out_sel) begin
      next_pin = seconds_clk;
    end else begin
      next_pin = alarm_en && pulse;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtc_pin_out <= 1'b0;
      rtc_pin_oe  <= 1'b0;
    end else begin
      rtc_pin_out <= next_pin;
      rtc_pin_oe  <= clk_on && pin_oe_en;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_match_flag: assert property (
    time_tick && clk_on && alarm_en && !wr_alarm && !wr_clock
    && mask_match(alarm_mask, time_now, alarm_set) |-> ##2 alarm_flag)
    else $error("match did not set flag two cycles later");
  a_flag_delay: assert property (
    $rose(alarm_flag) |-> $past(match_hit) && !$past(match_hit, 2)
    || $past(match_hit))
    else $error("flag rose without a prior match");
  a_flag_hold: assert property (
    alarm_flag && !flag_clear |=> alarm_flag)
    else $error("flag dropped without a clear");
  a_pulse_toggle: assert property (
    alarm_event && !wr_alarm |=> pulse != $past(pulse))
    else $error("pulse did not toggle on event");
  a_pulse_load: assert property (
    wr_alarm && hwdata[RTCAL_ALARM_EN_BIT] && !alarm_en
    |=> pulse == $past(hwdata[RTCAL_PIV_BIT]))
    else $error("pulse not loaded from initial value");
  a_pin_inactive: assert property (
    !alarm_en && !out_sel && !pclk_sel |=> !rtc_pin_out)
    else $error("pulse pin active while alarm disabled");
  a_irq_gate: assert property (
    irq_request |-> $past(alarm_flag && irq_enable && prio.group != 3'h0
                          && prio.group > cpu_level))
    else $error("interrupt requested without enable or priority");
  a_repeat_end: assert property (
    alarm_event && rpt_count == 8'h00 && !chime && !wr_alarm
    |=> !alarm_en && rpt_count == 8'h00)
    else $error("final alarm left enable set");
  a_chime_wrap: assert property (
    alarm_event && rpt_count == 8'h00 && chime && !wr_alarm
    |=> alarm_en && rpt_count == RTCAL_RPT_WRAP)
    else $error("chime did not wrap repeat count");
  a_deep_wake: assert property (
    deep_sleep && alarm_flag |=> wake_request)
    else $error("deep sleep alarm did not wake");

  c_alarm_event: cover property (alarm_event ##1 alarm_flag);
  c_chime_wrap: cover property (alarm_event && chime && rpt_count == 8'h00);
  c_deep_wake: cover property (deep_sleep && $rose(wake_request));
  c_peer_wins: cover property (alarm_flag && irq_enable && peer_request
                               && !alarm_wins);
endmodule : rtcal_alarm

// ---- sim/rtcal_tick_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Timekeeper side: half-second tick, seconds clock, raw clock
module rtcal_tick_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tick_cmd,
  output logic      time_tick,
  output logic      seconds_clk,
  output logic      prescaler_clk
);
  // One tick per command; seconds clock steps on every tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_tick   <= 1'b0;
      seconds_clk <= 1'b0;
    end else begin
      time_tick <= tick_cmd;
      if (tick_cmd)
        seconds_clk <= ~seconds_clk;
    end
  end

  // Free oscillator, phase unrelated to hclk so the sync is exercised
  initial begin
    prescaler_clk = 1'b0;
    forever #170 prescaler_clk = ~prescaler_clk;
  end
endmodule : rtcal_tick_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import rtcal_pkg::*;
;
  typedef struct {string nm; logic [31:0] v;} rtcal_note_type;
  localparam logic [5:0] VEC = 6'h10;
  logic           hclk;
  logic           hresetn = 1'b0;
  logic           hsel = 1'b1;
  logic [31:0]    haddr = 32'h0;
  logic [1:0]     htrans = 2'b00;
  logic           hwrite = 1'b0;
  logic [2:0]     hsize = 3'h2;
  logic [31:0]    hwdata = 32'h0;
  logic [31:0]    hrdata;
  logic           hreadyout, hresp, irq_request, wake_request;
  logic           rtc_pin_out, rtc_pin_oe, tick_cmd = 1'b0;
  logic           time_tick, seconds_clk, prescaler_clk;
  rtcal_time_type time_now = '0;
  logic [2:0]     cpu_level = 3'h0;
  logic           sleep_mode = 1'b0;
  logic           deep_sleep = 1'b0;
  logic           peer_request = 1'b0;
  rtcal_prio_type peer_prio = '0;
  logic [5:0]     peer_vector = 6'h0;
  logic [5:0]     irq_vector;
  logic           pulse = 1'b0, en = 1'b0, ch = 1'b1, pulse_initial_value = 1'b0;
  logic [7:0]     rpt;
  int             seed = 32'h39C0;
  int             error_cnt = 0;
  int             check_count = 0;
  rtcal_note_type exp_q[$];
  logic [31:0]    seen_q[$];

  rtcal_alarm #(.ALARM_VECTOR(VEC)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .time_now(time_now),
    .time_tick(time_tick), .seconds_clk(seconds_clk),
    .prescaler_clk(prescaler_clk), .cpu_level(cpu_level),
    .sleep_mode(sleep_mode), .deep_sleep(deep_sleep),
    .peer_request(peer_request), .peer_prio(peer_prio),
    .peer_vector(peer_vector), .irq_request(irq_request),
    .irq_vector(irq_vector), .wake_request(wake_request),
    .rtc_pin_out(rtc_pin_out), .rtc_pin_oe(rtc_pin_oe));

  rtcal_tick_model partner (
    .hclk(hclk), .hresetn(hresetn), .tick_cmd(tick_cmd),
    .time_tick(time_tick), .seconds_clk(seconds_clk),
    .prescaler_clk(prescaler_clk));

  // ==========================================================
  // Clock, watchdog and result checking
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Generous bound; the full run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    conclude();
  end

  // Oldest expectation meets oldest observation
  initial begin : watch
    rtcal_note_type n;
    logic [31:0] s;
    forever begin
      wait (seen_q.size() > 0);
      n = exp_q.pop_front();
      s = seen_q.pop_front();
      compare(n.nm, n.v, s);
    end
  end

  task automatic compare(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : compare

  task automatic note(input string nm, input logic [31:0] e, s);
    exp_q.push_back('{nm, e});
    seen_q.push_back(s);
  endtask : note

  task automatic conclude();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ==========================================================
  // Bus master: address phase held until hready, then data phase
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] s;
    xfer(a, 1'b1, d, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] s;
    xfer(a, 1'b0, 32'h0, s);
    note($sformatf("reg_%h", a), e, s);
    note("hresp", 32'h0, {31'h0, hresp});
  endtask : rd

  task automatic tick();
    @(posedge hclk);
    tick_cmd <= 1'b1;
    @(posedge hclk);
    tick_cmd <= 1'b0;
  endtask : tick

  // ==========================================================
  // One alarm trial: arm, tick, read flag, control, status, pin
  task automatic trial(input logic [3:0] m, input logic [31:0] irqc,
                       input logic hit, irq, wk);
    wr(RTCAL_IRQ_CTRL_ADDR, irqc | 32'h1);
    // Sync bit written high must read back low
    wr(RTCAL_ALARM_CTRL_ADDR, {16'h0, 1'b1, ch, pulse_initial_value, 1'b1, m, rpt});
    if (!en)
      pulse = pulse_initial_value;
    en = 1'b1;
    tick();
    repeat (4) @(posedge hclk);
    if (hit) begin
      pulse = ~pulse;
      if (rpt == 8'h00 && !ch)
        en = 1'b0;
      else
        rpt = rpt - 8'h01;
    end
    rd(RTCAL_IRQ_CTRL_ADDR, irqc | {31'h0, hit});
    rd(RTCAL_ALARM_CTRL_ADDR, {16'h0, en, ch, pulse_initial_value, 1'b0, m, rpt});
    if (en)
      rd(RTCAL_STATUS_ADDR, {29'h0, pulse, irq, wk});
    note("pin", {31'h0, en & pulse}, {31'h0, rtc_pin_out});
  endtask : trial

  // Priority case: drive CPU level, sleep and the competing source
  task automatic prio(input int g, ie, cpu, sl, dp, pr, pg, ps, pv,
                      input int irq, wk);
    @(posedge hclk);
    cpu_level    <= 3'(cpu);
    sleep_mode   <= 1'(sl);
    deep_sleep   <= 1'(dp);
    peer_request <= 1'(pr);
    peer_prio    <= '{3'(pg), 2'(ps)};
    peer_vector  <= 6'(pv);
    trial(RTCAL_M_HALF, {25'h0, 2'b00, 3'(g), 1'(ie), 1'b0}, 1'b1,
          1'(irq), 1'(wk));
  endtask : prio

  // ==========================================================
  // Main sequence
  initial begin
    int r, n;
    logic last;
    logic [7:0] sec, mn;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 28; a += 4)
      rd(8'(a), 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0);
    note("irq_vector", {26'h0, VEC}, {26'h0, irq_vector});
    // Random time of day, alarm hour set one off
    r = $random(seed) & 32'hFFFF;
    sec = {4'(r % 6), 4'(r % 10)};
    mn = {4'(r / 7 % 6), 4'(r % 9)};
    rpt = 8'(r % 3);
    @(posedge hclk);
    time_now <= '{8'h06, 8'h27, 8'h05, 8'h16, mn, sec, 1'b0};
    wr(RTCAL_CLOCK_CTRL_ADDR, 32'h0000_8001);
    wr(RTCAL_ALARM_TIME_ADDR, {8'h17, mn, sec, 8'h00});
    wr(RTCAL_ALARM_DATE_ADDR, 32'h0006_2705);
    note("pin_oe", 32'h1, {31'h0, rtc_pin_oe});
    for (int m = 0; m < 16; m++)
      trial(4'(m), {27'h0, 3'h3, m[0], 1'b0}, m < 6, m < 6 && m[0],
            1'b0);
    wr(RTCAL_ALARM_TIME_ADDR, {8'h16, mn, sec, 8'h00});
    trial(RTCAL_M_YEAR, 32'h0C, 1'b1, 1'b0, 1'b0);
    wr(RTCAL_ALARM_DATE_ADDR, 32'h0007_2705);
    trial(RTCAL_M_YEAR, 32'h0C, 1'b0, 1'b0, 1'b0);
    trial(RTCAL_M_WEEK, 32'h0C, 1'b1, 1'b0, 1'b0);
    prio(0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    prio(3, 1, 3, 0, 0, 0, 0, 0, 0, 0, 0);
    prio(3, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0);
    prio(3, 1, 2, 1, 0, 0, 0, 0, 0, 1, 1);
    prio(0, 0, 7, 0, 1, 0, 0, 0, 0, 0, 1);
    prio(3, 1, 0, 0, 0, 1, 3, 0, 17, 1, 0);
    prio(3, 1, 0, 0, 0, 1, 3, 1, 17, 0, 0);
    prio(3, 1, 0, 0, 0, 1, 4, 0, 17, 0, 0);
    prio(3, 1, 0, 0, 0, 1, 2, 3, 15, 1, 0);
    // Alarm subpriority 2 beats a same-group source at subpriority 1
    peer_prio <= '{3'h3, 2'h1};
    trial(RTCAL_M_HALF, 32'h4E, 1'b1, 1'b1, 1'b0);
    prio(3, 1, 0, 0, 0, 1, 3, 0, 15, 0, 0);
    // Competing source withdraws; the held alarm goes out
    @(posedge hclk);
    peer_request <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(RTCAL_STATUS_ADDR, {29'h0, pulse, 2'b10});
    // Last repeat without chime turns the alarm off
    ch = 1'b0;
    rpt = 8'h01;
    trial(RTCAL_M_HALF, 32'h0C, 1'b1, 1'b0, 1'b0);
    trial(RTCAL_M_HALF, 32'h0C, 1'b1, 1'b0, 1'b0);
    ch = 1'b1;
    pulse_initial_value = 1'b1;
    trial(RTCAL_M_HALF, 32'h0C, 1'b1, 1'b0, 1'b0);
    // Pin carries the seconds clock
    wr(RTCAL_CLOCK_CTRL_ADDR, 32'h0000_8081);
    repeat (2) begin
      tick();
      repeat (4) @(posedge hclk);
      note("pin_sec", {31'h0, seconds_clk}, {31'h0, rtc_pin_out});
    end
    // Pin carries the raw clock: 3000 ns holds 17 or 18 edges
    wr(RTCAL_CLOCK_CTRL_ADDR, 32'h0000_8181);
    repeat (6) @(posedge hclk);
    n = 0;
    last = rtc_pin_out;
    repeat (120) begin
      @(posedge hclk);
      n += int'(rtc_pin_out != last);
      last = rtc_pin_out;
    end
    note("pin_pclk", 32'h1, {31'h0, n > 15 && n < 20});
    wr(RTCAL_CLOCK_CTRL_ADDR, 32'h0000_0181);
    repeat (2) @(posedge hclk);
    note("pin_oe", 32'h0, {31'h0, rtc_pin_oe});
    repeat (2) @(posedge hclk);
    conclude();
  end
endmodule : tb_top
